// ---- core/wdgopt_core.v ----
// watchdog core with factory option bits, reset pulse and interrupt
// assumes a synchronous bus master and a cpu that reports stop and wait
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`include "wdgopt_defines.vh"

module wdgopt_core #(
  parameter [7:0] OPTIONS = `OPT_RESET,
  parameter [7:0] VECTOR_LOW = 8'h00,
  parameter [12:0] POR_CYCLES = `POR_CYCLES,
  parameter [12:0] LONG_REC = `LONG_REC_CYCLES
) (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // register port
  input wire [15:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  // cpu status, same clock
  input wire stop_exec_in,
  input wire wait_in,
  input wire wake_in,
  input wire lvi_reset_in,
  input wire break_in,
  input wire monitor_in,
  input wire monitor_blank_in,
  // pins from outside
  input wire rst_tst_pin_in,
  input wire irq_tst_pin_in,
  // outputs
  output wire sys_reset_out,
  output wire illegal_reset_out,
  output wire rst_pin_out,
  output wire rst_pin_oe_out,
  output wire stopped_out,
  output wire irq_out
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [1:0] rst_tst_sync_ff;
  reg [1:0] irq_tst_sync_ff;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rst_tst_sync_ff <= 2'h0;
      irq_tst_sync_ff <= 2'h0;
    end else begin
      rst_tst_sync_ff <= {rst_tst_sync_ff[0], rst_tst_pin_in};
      irq_tst_sync_ff <= {irq_tst_sync_ff[0], irq_tst_pin_in};
    end
  end
  wire rst_tst = rst_tst_sync_ff[1];
  wire irq_tst = irq_tst_sync_ff[1];

  // ****************************************
  // state
  // ****************************************
  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_STOP = 3'h2;
  localparam [2:0] ST_RECOVER = 3'h4;

  reg [2:0] state_ff;
  reg [`PRE_WIDTH-1:0] pre_ff;
  reg [`WDG_WIDTH-1:0] wdg_ff;
  reg [12:0] por_cnt_ff;
  reg por_done_ff;
  reg [12:0] rec_cnt_ff;
  reg [5:0] pulse_cnt_ff;
  reg blank_lock_ff;
  reg cause_wdg_ff;
  reg [`ST_WIDTH-1:0] status_ff;
  reg [`ST_WIDTH-1:0] mask_ff;

  wire opt_disable = OPTIONS[`OPT_DISABLE_BIT];
  wire opt_rate = OPTIONS[`OPT_RATE_BIT];
  wire opt_stop_en = OPTIONS[`OPT_STOP_EN_BIT];
  wire opt_short = OPTIONS[`OPT_SHORT_REC_BIT];

  function is_addr;
    input [15:0] a;
    input [15:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  wire service_wr = wr_in && is_addr(addr_in, `WDG_SERVICE_ADDR);
  wire stop_ok = stop_exec_in && opt_stop_en && (state_ff == ST_RUN);
  wire stop_bad = stop_exec_in && !opt_stop_en && (state_ff == ST_RUN);

  wire wdg_off = opt_disable || blank_lock_ff ||
                 (monitor_in && (rst_tst || irq_tst)) ||
                 (break_in && rst_tst);

  // wait does not gate the count
  wire clk_run = (state_ff != ST_STOP);

  // ****************************************
  // counters
  // ****************************************
  // tap selection: short tap at pre bit 6 gives 127*64+... exact
  // carry taps: pre carry at 4096 feeds the long count, 128 the short
  wire [`PRE_WIDTH:0] pre_sum = {1'b0, pre_ff} + 13'h0001;
  wire tap_short = (pre_ff[6:0] == 7'h7f);
  wire tap_long = pre_sum[`PRE_WIDTH];
  wire wdg_tick = clk_run && (opt_rate ? tap_short : tap_long);
  // overflow point, cycle counts come out as 64*4096-16, 64*128-16
  wire at_long = (wdg_ff == 6'h3f) && (pre_ff == 12'hfef);
  wire at_short = (wdg_ff == 6'h3f) && (pre_ff[6:0] == 7'h6f);
  wire overflow = clk_run && !wdg_off && (opt_rate ? at_short : at_long);
  wire pulse_busy = (pulse_cnt_ff != 6'h00);
  wire internal_rst = overflow || stop_bad;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      pre_ff <= 12'h000;
      wdg_ff <= 6'h00;
    end else if (internal_rst || pulse_busy) begin
      pre_ff <= 12'h000;
      wdg_ff <= 6'h00;
    end else if (stop_ok || (!por_done_ff && por_cnt_ff == POR_CYCLES - 13'h0001)) begin
      pre_ff <= 12'h000;
    end else if (service_wr) begin
      // service clears counter and stages 12-5
      wdg_ff <= 6'h00;
      pre_ff <= {8'h00, pre_ff[3:0]};
    end else if (clk_run) begin
      pre_ff <= pre_sum[`PRE_WIDTH-1:0];
      if (wdg_tick) begin
        wdg_ff <= wdg_ff + 6'h01;
      end
    end
  end

  // ****************************************
  // power-up, stop recovery, reset pulse
  // ****************************************
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      por_cnt_ff <= 13'h0000;
      por_done_ff <= 1'b0;
      blank_lock_ff <= 1'b0;
    end else begin
      if (!por_done_ff) begin
        por_cnt_ff <= por_cnt_ff + 13'h0001;
        if (por_cnt_ff == POR_CYCLES - 13'h0001) begin
          por_done_ff <= 1'b1;
        end
      end
      // blank vector entry held until power-on
      if (monitor_blank_in && !irq_tst) begin
        blank_lock_ff <= 1'b1;
      end
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_RUN;
      rec_cnt_ff <= 13'h0000;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (stop_ok) begin
            state_ff <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (wake_in || lvi_reset_in) begin
            state_ff <= ST_RECOVER;
            if (lvi_reset_in || !opt_short) begin
              rec_cnt_ff <= LONG_REC - 13'h0001;
            end else begin
              rec_cnt_ff <= `SHORT_REC_CYCLES - 13'h0001;
            end
          end
        end
        ST_RECOVER: begin
          if (rec_cnt_ff == 13'h0000) begin
            state_ff <= ST_RUN;
          end else begin
            rec_cnt_ff <= rec_cnt_ff - 13'h0001;
          end
        end
        default: begin
          state_ff <= ST_RUN;
        end
      endcase
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      pulse_cnt_ff <= 6'h00;
    end else if (internal_rst && !pulse_busy) begin
      pulse_cnt_ff <= `RST_PULSE_CYCLES;
    end else if (pulse_busy) begin
      pulse_cnt_ff <= pulse_cnt_ff - 6'h01;
    end
  end

  // ****************************************
  // status, mask, cause
  // ****************************************
  wire [`ST_WIDTH-1:0] events;
  assign events[`ST_TIMEOUT_BIT] = overflow;
  assign events[`ST_ILLEGAL_BIT] = stop_bad;
  assign events[`ST_RECOVER_BIT] = (state_ff == ST_RECOVER) && (rec_cnt_ff == 13'h0000);
  wire status_clr = wr_in && is_addr(addr_in, `WDG_STATUS_ADDR);

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      status_ff <= 3'h0;
      mask_ff <= 3'h0;
      cause_wdg_ff <= 1'b0;
    end else begin
      // set wins over write-one clear
      status_ff <= (status_ff & ~(status_clr ? wdata_in[`ST_WIDTH-1:0] : 3'h0)) | events;
      if (wr_in && is_addr(addr_in, `WDG_MASK_ADDR)) begin
        mask_ff <= wdata_in[`ST_WIDTH-1:0];
      end
      // cause flag, kept over the pulse
      if (overflow) begin
        cause_wdg_ff <= 1'b1;
      end else if (stop_bad) begin
        cause_wdg_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `WDG_SERVICE_ADDR: rdata_out <= VECTOR_LOW;
        `WDG_OPTIONS_ADDR: rdata_out <= OPTIONS;
        `WDG_STATUS_ADDR: rdata_out <= {5'h00, status_ff};
        `WDG_MASK_ADDR: rdata_out <= {5'h00, mask_ff};
        `WDG_CAUSE_ADDR: rdata_out <= {7'h00, cause_wdg_ff};
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // only a system-level flag line, no cpu request
  assign irq_out = |(status_ff & mask_ff);
  assign sys_reset_out = internal_rst || pulse_busy;
  assign illegal_reset_out = stop_bad;
  // open drain: drive low only
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_out = pulse_busy;
  assign stopped_out = (state_ff != ST_RUN);

endmodule

// ---- core/wdgopt_defines.vh ----
// constants for the watchdog with option bits block
// assumes a single clock standing in for the crystal oscillator clock
`ifndef WDGOPT_DEFINES_VH
`define WDGOPT_DEFINES_VH

// ****************************************
// register offsets
// ****************************************
`define WDG_SERVICE_ADDR 16'hffff
`define WDG_OPTIONS_ADDR 16'hff80
`define WDG_STATUS_ADDR 16'hff81
`define WDG_MASK_ADDR 16'hff82
`define WDG_CAUSE_ADDR 16'hff83

// ****************************************
// option register field positions
// ****************************************
`define OPT_RATE_BIT 0
`define OPT_STOP_EN_BIT 1
`define OPT_SHORT_REC_BIT 3
`define OPT_DISABLE_BIT 7

// status / mask fields
`define ST_TIMEOUT_BIT 0
`define ST_ILLEGAL_BIT 1
`define ST_RECOVER_BIT 2
`define ST_WIDTH 3

// ****************************************
// reset values and timing counts
// ****************************************
`define OPT_RESET 8'h00
`define PRE_WIDTH 12
`define WDG_WIDTH 6
`define RST_PULSE_CYCLES 6'h20
`define SHORT_REC_CYCLES 13'h0020
`define LONG_REC_CYCLES 4096
`define POR_CYCLES 4096
`define LONG_TIMEOUT 262128
`define SHORT_TIMEOUT 8176

`endif

// ---- testbench/wdgopt_chk_props.sv ----
// assertions on the pins of the watchdog core
// assumes it is bound into every instance of the core
`timescale 1ns/10ps
module wdgopt_chk #(
  parameter [7:0] VECTOR_LOW = 8'h00
) (
  // clock, reset and bus
  input wire clk_in,
  input wire rst_n_in,
  input wire [15:0] addr_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  // reset and status outputs
  input wire sys_reset_out,
  input wire illegal_reset_out,
  input wire rst_pin_out,
  input wire rst_pin_oe_out,
  input wire stopped_out,
  input wire irq_out
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_pulse_len: assert property ($rose(rst_pin_oe_out) |-> ##31 rst_pin_oe_out ##1 !rst_pin_oe_out)
    else $error("reset pulse not 32 cycles");
  a_pin_low: assert property (rst_pin_out == 1'b0)
    else $error("reset pin driven high");
  a_sys_pin: assert property (rst_pin_oe_out |-> sys_reset_out)
    else $error("pin pulse without system reset");
  a_ill_sys: assert property (illegal_reset_out |-> sys_reset_out)
    else $error("illegal stop without system reset");
  a_rd_vector: assert property (rd_in && addr_in == 16'hffff |=> rdata_out == VECTOR_LOW)
    else $error("service read not vector low");
  a_rd_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data outside answer cycle");
  a_svc_quiet: assert property (wr_in && addr_in == 16'hffff && !rst_pin_oe_out
    |=> (!$rose(rst_pin_oe_out))[*8])
    else $error("timeout right after service");
  a_stop_quiet: assert property (stopped_out |=> !$rose(rst_pin_oe_out))
    else $error("timeout while stopped");
  // reset itself must clear the pulse, so no disable here
  a_rst_clear: assert property (disable iff (1'b0) !rst_n_in |=> !rst_pin_oe_out)
    else $error("pulse survives reset");
  c_timeout: cover property ($rose(rst_pin_oe_out));
  c_stop: cover property ($rose(stopped_out));
  c_irq: cover property ($rose(irq_out));
endmodule
bind wdgopt_core wdgopt_chk #(.VECTOR_LOW(VECTOR_LOW)) u_wdgopt_chk (.*);

// ---- testbench/wdgopt_core_bench.sv ----
// bench for the watchdog core: registers, timeout, stop, disable
// assumes short power-up and recovery parameters, fast rate option
`timescale 1ns/10ps
`include "wdgopt_defines.vh"
module wdgopt_core_bench;
  reg clk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg [15:0] addr_in = 16'h0000;
  reg [7:0] wdata_in = 8'h00;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  reg stop_exec_in = 1'b0;
  reg wake_in = 1'b0;
  reg wait_in = 1'b0;
  reg monitor_in = 1'b0;
  reg irq_tst_pin_in = 1'b0;
  reg rst_tst_pin_in = 1'b0;
  reg break_in = 1'b0;
  reg lvi_reset_in = 1'b0;
  wire [7:0] rdata_out;
  wire sys_reset_out, illegal_reset_out, rst_pin_out, rst_pin_oe_out, stopped_out, irq_out;
  int n_errors = 0;
  int samples_checked = 0;
  int n;
  // ****************************************
  // device and helpers
  // ****************************************
  wdgopt_core #(.OPTIONS(8'h03), .VECTOR_LOW(8'h5a), .POR_CYCLES(13'h0010),
    .LONG_REC(13'h0040)) u_wdgopt_core (.monitor_blank_in(1'b0), .*);
  initial forever #4 clk_in = ~clk_in;
  task close_out;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input bit c, input string m);
    samples_checked++;
    if (!c) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input [15:0] a, input [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out === e, "read data");
  endtask
  // counts cycles until the pin pulse; a required pulse that never comes ends the run
  task run(input int lim, input bit must);
    n = 0;
    while (rst_pin_oe_out !== 1'b1 && n < lim) begin
      @(posedge clk_in);
      #1 n++;
    end
    if (must && n >= lim) begin
      chk(1'b0, "no timeout");
      close_out;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_regs;
    rd(`WDG_OPTIONS_ADDR, 8'h03);
    rd(`WDG_SERVICE_ADDR, 8'h5a);
    wr(`WDG_OPTIONS_ADDR, 8'hff);
    rd(`WDG_OPTIONS_ADDR, 8'h03);
    rd(16'h0000, 8'h00);
    rd(`WDG_STATUS_ADDR, 8'h00);
    $display("t_regs done");
  endtask
  task t_timeout;
    wait_in <= 1'b1;
    wr(`WDG_SERVICE_ADDR, 8'h00);
    run(9000, 1'b1);
    chk(n >= `SHORT_TIMEOUT - 16 && n <= `SHORT_TIMEOUT + 2, "period");
    n = 0;
    while (rst_pin_oe_out === 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk(n == `RST_PULSE_CYCLES, "pulse length");
    rd(`WDG_CAUSE_ADDR, 8'h01);
    rd(`WDG_STATUS_ADDR, 8'h01);
    chk(irq_out === 1'b0, "masked irq");
    wr(`WDG_MASK_ADDR, 8'h01);
    #1 chk(irq_out === 1'b1, "irq on");
    wr(`WDG_STATUS_ADDR, 8'h01);
    #1 chk(irq_out === 1'b0, "irq cleared");
    wait_in <= 1'b0;
    $display("t_timeout done");
  endtask
  task t_service;
    repeat (3) begin
      wr(`WDG_SERVICE_ADDR, 8'ha5);
      run(4000, 1'b0);
      chk(n == 4000, "serviced timeout");
    end
    $display("t_service done");
  endtask
  task t_stop;
    wr(`WDG_SERVICE_ADDR, 8'h00);
    @(posedge clk_in);
    stop_exec_in <= 1'b1;
    @(posedge clk_in);
    stop_exec_in <= 1'b0;
    #1 chk(stopped_out === 1'b1, "stopped");
    run(9000, 1'b0);
    chk(n == 9000, "timeout in stop");
    @(posedge clk_in);
    wake_in <= 1'b1;
    @(posedge clk_in);
    wake_in <= 1'b0;
    n = 0;
    while (stopped_out === 1'b1 && n < 200) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk(n >= 62 && n <= 66, "recovery");
    rd(`WDG_STATUS_ADDR, 8'h04);
    $display("t_stop done");
  endtask
  task t_disable;
    wr(`WDG_SERVICE_ADDR, 8'h00);
    monitor_in <= 1'b1;
    irq_tst_pin_in <= 1'b1;
    run(9000, 1'b0);
    chk(n == 9000, "timeout in monitor");
    monitor_in <= 1'b0;
    irq_tst_pin_in <= 1'b0;
    run(9000, 1'b1);
    repeat (40) @(posedge clk_in);
    $display("t_disable done");
  endtask
  task t_break_lvi;
    wr(`WDG_SERVICE_ADDR, 8'h00);
    break_in <= 1'b1;
    rst_tst_pin_in <= 1'b1;
    run(9000, 1'b0);
    chk(n == 9000, "timeout in break");
    break_in <= 1'b0;
    rst_tst_pin_in <= 1'b0;
    wr(`WDG_SERVICE_ADDR, 8'h00);
    @(posedge clk_in);
    stop_exec_in <= 1'b1;
    @(posedge clk_in);
    stop_exec_in <= 1'b0;
    lvi_reset_in <= 1'b1;
    @(posedge clk_in);
    lvi_reset_in <= 1'b0;
    n = 0;
    while (stopped_out === 1'b1 && n < 200) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk(n >= 62 && n <= 66, "lvi recovery");
    $display("t_break_lvi done");
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_timeout;
    t_service;
    t_stop;
    t_disable;
    t_break_lvi;
    close_out;
  end
endmodule
